// ===== core/csr_reporter.sv
// Single-wire pulse count status reporter, device end
// Assumes an external pull-up on the line and line input synchronous to mclk
// Behaviour
// - Reply starts only after strobe rising edge plus report start delay.
// - Reply is low pulses at a fixed pulse period.
// - Each request gives exactly one reply selecting one of 22 states.
// - Counts 1-3 faults, 4 unused, 5-12 adapter states.
// - Counts 13-17 report high-current USB phases in order.
// - Counts 18-22 low-current USB phases; 23 is report error.
// - Line is active low, idle high; parties only pull low or release.
// - Same line senses the strobe and then carries the reply.
// - Over-voltage fault is readable through the report only while no die or battery temperature fault is set.
// - Watchdog codes appear only in adapter charging.
`timescale 1ns/100ps
module csr_reporter
    import csr_pkg::*;
#(
    parameter int DELAY_CYC = REPORT_DELAY_CYC,
    parameter int PERIOD_CYC = PULSE_PERIOD_CYC,
    parameter int STRB_MAX_CYC = STROBE_MAX_CYC
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Charger state
    input wire csr_state_s chgState,
    // Shared status line
    input wire logic lineIn,
    output logic lineOut,
    output logic lineOe_n,
    // Activity
    output logic busy
);
    // ************************************************************
    // State
    // ************************************************************
    typedef enum logic [1:0] {ST_IDLE, ST_STROBE, ST_DELAY, ST_PULSE}
        csr_fsm_e;
    csr_fsm_e state_r, state_nxt;
    logic [CNT_W-1:0] timer_r, timer_nxt;
    logic [4:0] left_r, left_nxt;
    logic [4:0] code;
    logic lineOe_n_r, lineOe_n_nxt;
    logic busy_r, busy_nxt;

    csr_encoder u_enc (
        .chgState(chgState),
        .count(code)
    );

    // ************************************************************
    // Sequencer
    // ************************************************************
    // Next state: sense strobe, wait, then pulse the count out
    always_comb begin
        state_nxt = state_r;
        timer_nxt = timer_r;
        left_nxt = left_r;
        lineOe_n_nxt = 1'b1;
        busy_nxt = 1'b1;
        case (state_r)
            ST_IDLE: begin
                busy_nxt = 1'b0;
                timer_nxt = '0;
                if (!lineIn) begin
                    state_nxt = ST_STROBE;
                    busy_nxt = 1'b1;
                end
            end
            ST_STROBE: begin
                if (timer_r != CNT_W'(STRB_MAX_CYC)) begin
                    timer_nxt = timer_r + 1'b1;
                end
                if (lineIn) begin
                    state_nxt = ST_DELAY;
                    timer_nxt = '0;
                    // Overlong strobe gives the error report
                    left_nxt = (timer_r >= CNT_W'(STRB_MAX_CYC)) ?
                        CODE_ERROR : code;
                end
            end
            ST_DELAY: begin
                timer_nxt = timer_r + 1'b1;
                if (timer_r == CNT_W'(DELAY_CYC - 1)) begin
                    state_nxt = ST_PULSE;
                    timer_nxt = '0;
                end
            end
            ST_PULSE: begin
                // Low for the first half of each period
                lineOe_n_nxt = (timer_r >= CNT_W'(PERIOD_CYC / 2));
                timer_nxt = timer_r + 1'b1;
                if (timer_r == CNT_W'(PERIOD_CYC - 1)) begin
                    timer_nxt = '0;
                    left_nxt = left_r - 5'h01;
                    if (left_r == 5'h01) begin
                        state_nxt = ST_IDLE;
                        busy_nxt = 1'b0;
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                busy_nxt = 1'b0;
            end
        endcase
    end

    // Registers
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            timer_r <= '0;
            left_r <= '0;
            lineOe_n_r <= 1'b1;
            busy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            timer_r <= timer_nxt;
            left_r <= left_nxt;
            lineOe_n_r <= lineOe_n_nxt;
            busy_r <= busy_nxt;
        end
    end

    // Only ever pulls low
    assign lineOut = 1'b0;
    assign lineOe_n = lineOe_n_r;
    assign busy = busy_r;

    // ************************************************************
    // Checks
    // ************************************************************
    // Strobe seen ending while still in the strobe state
    sequence strobeEnd;
        state_r == ST_STROBE && lineIn;
    endsequence

    // Strobe ending within the maximum width
    sequence strobeEndShort;
        state_r == ST_STROBE && lineIn && timer_r < CNT_W'(STRB_MAX_CYC);
    endsequence

    // Strobe ending past the maximum width
    sequence strobeEndLong;
        state_r == ST_STROBE && lineIn && timer_r >= CNT_W'(STRB_MAX_CYC);
    endsequence

    // First cycle of a reply period
    sequence periodStart;
        state_r == ST_PULSE && timer_r == '0;
    endsequence

    // Middle of a reply period, where the low pulse ends
    sequence periodMid;
        state_r == ST_PULSE && timer_r == CNT_W'(PERIOD_CYC / 2);
    endsequence

    // Last cycle of the reply burst
    sequence burstEnd;
        state_r == ST_PULSE && state_nxt == ST_IDLE;
    endsequence

    // Line handling around the request strobe
    chk_release_idle: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (state_r == ST_IDLE) |=> lineOe_n)
        else $error("line driven while idle");
    chk_strobe_seen: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (state_r == ST_IDLE && !lineIn) |=> (state_r == ST_STROBE && busy))
        else $error("strobe not taken");
    chk_delay_first: assert property (
        @(posedge mclk) disable iff (!reset_n)
        strobeEnd |=> lineOe_n [*2])
        else $error("reply started before delay");

    // Count latched at the strobe end
    chk_count_range: assert property (
        @(posedge mclk) disable iff (!reset_n)
        strobeEnd |=> (left_r >= 5'h01 && left_r <= CODE_ERROR &&
        left_r != 5'h04))
        else $error("pulse count out of range");
    chk_code_latch: assert property (
        @(posedge mclk) disable iff (!reset_n)
        strobeEndShort |=> left_r == $past(code))
        else $error("latched count differs from state");
    chk_long_strobe: assert property (
        @(posedge mclk) disable iff (!reset_n)
        strobeEndLong |=> left_r == CODE_ERROR)
        else $error("overlong strobe not reported");

    // Pulse shape of the reply
    chk_pulse_start: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (state_r == ST_DELAY && state_nxt == ST_PULSE) |=> ##1 !lineOe_n)
        else $error("pulse did not start");
    chk_pulse_low: assert property (
        @(posedge mclk) disable iff (!reset_n)
        periodStart |=> !lineOe_n)
        else $error("period did not open low");
    chk_pulse_high: assert property (
        @(posedge mclk) disable iff (!reset_n)
        periodMid |=> lineOe_n)
        else $error("pulse not released mid period");
    chk_one_reply: assert property (
        @(posedge mclk) disable iff (!reset_n)
        burstEnd |-> left_r == 5'h01)
        else $error("reply ended with pulses left");
    chk_burst_done: assert property (
        @(posedge mclk) disable iff (!reset_n)
        burstEnd |=> (state_r == ST_IDLE && !busy && lineOe_n))
        else $error("burst did not end cleanly");

    // Encoding of the charger state
    chk_fault_first: assert property (
        @(posedge mclk) disable iff (!reset_n)
        chgState.dieHot |-> code == CODE_DIE_HOT)
        else $error("die fault not first");
    chk_ov_code: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (!chgState.dieHot && !chgState.batTempFault && chgState.overVolt)
        |-> code == CODE_OVER_VOLT)
        else $error("over-voltage not reported");
    chk_wd_adapter: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (chgState.source != SRC_ADAPTER) |-> !(code inside {5'h05, 5'h07,
        5'h0A}))
        else $error("watchdog code outside adapter");
    chk_usb_high_current_band: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (chgState.source == SRC_USB_HIGH_CURRENT && !chgState.dieHot &&
        !chgState.batTempFault && !chgState.overVolt &&
        chgState.phase inside {PH_COND, PH_REDUCE, PH_CC, PH_CV, PH_DONE})
        |-> code inside {[CODE_USB_HIGH_CURRENT_BASE:5'h11]})
        else $error("high-current code off band");
    chk_usb_low_current_band: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (chgState.source == SRC_USB_LOW_CURRENT && !chgState.dieHot &&
        !chgState.batTempFault && !chgState.overVolt &&
        chgState.phase inside {PH_COND, PH_REDUCE, PH_CC, PH_CV, PH_DONE})
        |-> code inside {[CODE_USB_LOW_CURRENT_BASE:5'h16]})
        else $error("low-current code off band");
endmodule

// ===== core/csr_pkg.sv
// Package for the charge status pulse reporter
// Assumes a 250 MHz mclk; all times are turned into cycle counts here
package csr_pkg;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_PS = 4000;
    localparam int STROBE_MIN_NS = 200;
    localparam int STROBE_MIN_CYC = (STROBE_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    // Report start delay, pulse period and low time (plain defaults)
    localparam int REPORT_DELAY_NS = 1000;
    localparam int REPORT_DELAY_CYC = REPORT_DELAY_NS * 1000 / CLK_PERIOD_PS;
    localparam int PULSE_PERIOD_NS = 400;
    localparam int PULSE_PERIOD_CYC = PULSE_PERIOD_NS * 1000 / CLK_PERIOD_PS;
    localparam int PULSE_LOW_CYC = PULSE_PERIOD_CYC / 2;
    localparam int STROBE_MAX_NS = 20000;
    localparam int STROBE_MAX_CYC = STROBE_MAX_NS * 1000 / CLK_PERIOD_PS;
    localparam int CNT_W = 16;

    // ************************************************************
    // Pulse count codes
    // ************************************************************
    localparam logic [4:0] CODE_DIE_HOT = 5'h01;
    localparam logic [4:0] CODE_BAT_TEMP = 5'h02;
    localparam logic [4:0] CODE_OVER_VOLT = 5'h03;
    localparam logic [4:0] CODE_ADP_BASE = 5'h05;
    localparam logic [4:0] CODE_USB_HIGH_CURRENT_BASE = 5'h0D;
    localparam logic [4:0] CODE_USB_LOW_CURRENT_BASE = 5'h12;
    localparam logic [4:0] CODE_ERROR = 5'h17;

    typedef enum logic [1:0] {SRC_NONE, SRC_ADAPTER, SRC_USB_HIGH_CURRENT, SRC_USB_LOW_CURRENT}
        csr_src_e;
    typedef enum logic [2:0] {PH_COND, PH_REDUCE, PH_CC, PH_THERMAL, PH_CV,
        PH_DONE} csr_phase_e;

    // Charger state as seen by the reporter
    typedef struct packed {
        logic dieHot;
        logic batTempFault;
        logic overVolt;
        logic watchdogOut;
        csr_src_e source;
        csr_phase_e phase;
    } csr_state_s;
endpackage

// ===== core/csr_encoder.sv
// Maps the charger state onto one pulse count
// Assumes the state input is stable while it is sampled
`timescale 1ns/100ps
module csr_encoder
    import csr_pkg::*;
(
    // Charger state
    input wire csr_state_s chgState,
    // Pulse count
    output logic [4:0] count
);
    // ************************************************************
    // Encoding
    // ************************************************************
    // Faults first, then the source dependent charge phase
    always_comb begin
        count = CODE_ERROR;
        if (chgState.dieHot) begin
            count = CODE_DIE_HOT;
        end else if (chgState.batTempFault) begin
            count = CODE_BAT_TEMP;
        end else if (chgState.overVolt) begin
            count = CODE_OVER_VOLT;
        end else begin
            case (chgState.source)
                SRC_ADAPTER: begin
                    // Watchdog codes only in adapter mode
                    case (chgState.phase)
                        PH_COND: count = chgState.watchdogOut ? 5'h05 : 5'h06;
                        PH_CC: count = chgState.watchdogOut ? 5'h07 : 5'h09;
                        PH_THERMAL: count = 5'h08;
                        PH_CV: count = chgState.watchdogOut ? 5'h0A : 5'h0B;
                        PH_DONE: count = 5'h0C;
                        default: count = CODE_ERROR;
                    endcase
                end
                SRC_USB_HIGH_CURRENT, SRC_USB_LOW_CURRENT: begin
                    // Five USB phases in order
                    case (chgState.phase)
                        PH_COND: count = 5'h00;
                        PH_REDUCE: count = 5'h01;
                        PH_CC: count = 5'h02;
                        PH_CV: count = 5'h03;
                        PH_DONE: count = 5'h04;
                        default: count = 5'h1F;
                    endcase
                    if (count == 5'h1F) begin
                        count = CODE_ERROR;
                    end else if (chgState.source == SRC_USB_HIGH_CURRENT) begin
                        count = count + CODE_USB_HIGH_CURRENT_BASE;
                    end else begin
                        count = count + CODE_USB_LOW_CURRENT_BASE;
                    end
                end
                default: count = CODE_ERROR;
            endcase
        end
    end
endmodule

// ===== tb/csr_host.sv
// Host model that queries the pulse count status line
// Assumes lineIn is the pulled-up line resolved from both pull-downs
`timescale 1ns/100ps
module csr_host (
    // Clock
    input wire logic mclk,
    // Shared line, high while this side pulls it low
    input wire logic lineIn,
    output logic hostLow
);
    initial hostLow = 1'b0;
    // Strobe, release, then count falling edges over a fixed window
    task automatic query(input int width, input int win, output int n,
        output int first, output int lows);
        logic prev;
        n = 0;
        first = 0;
        lows = 0;
        @(posedge mclk);
        hostLow <= 1'b1;
        repeat (width) @(posedge mclk);
        hostLow <= 1'b0;
        prev = 1'b1;
        for (int k = 1; k <= win; k++) begin
            @(posedge mclk);
            if (!lineIn) lows++;
            if (prev && !lineIn) begin
                n++;
                if (first == 0) first = k;
            end
            prev = lineIn;
        end
    endtask
endmodule

// ===== tb/charge_status_pulse_reporter_test.sv
// Self-checking bench for the status pulse reporter
// Assumes the host model in csr_host.sv and the csr_pkg package
`timescale 1ns/100ps
module charge_status_pulse_reporter_test;
    import csr_pkg::*;
    // ********************************************************
    // Setup
    // ********************************************************
    localparam int DLY = 4;
    localparam int PER = 8;
    localparam int SMAX = 200;
    localparam int WIN = DLY + 23 * PER + 14;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    csr_state_s st = '0;
    logic lineOut;
    logic lineOe_n;
    logic busy;
    logic hostLow;
    int error_cnt = 0;
    int checks_done = 0;
    // Pulled-up line, low while either party pulls it
    wire lineIn = !(hostLow || (!lineOe_n && !lineOut));
    always #2 mclk = ~mclk;
    csr_reporter #(.DELAY_CYC(DLY), .PERIOD_CYC(PER), .STRB_MAX_CYC(SMAX))
        u_dut (.mclk(mclk), .reset_n(reset_n), .chgState(st),
        .lineIn(lineIn), .lineOut(lineOut), .lineOe_n(lineOe_n),
        .busy(busy));
    csr_host u_host (.mclk(mclk), .lineIn(lineIn), .hostLow(hostLow));
    // Reference pulse count
    function automatic int exp_code(csr_state_s s);
        int b;
        if (s.dieHot) return 1;
        if (s.batTempFault) return 2;
        if (s.overVolt) return 3;
        if (s.source == SRC_ADAPTER) begin
            case (s.phase)
                PH_COND: return s.watchdogOut ? 5 : 6;
                PH_CC: return s.watchdogOut ? 7 : 9;
                PH_THERMAL: return 8;
                PH_CV: return s.watchdogOut ? 10 : 11;
                PH_DONE: return 12;
                default: return 23;
            endcase
        end
        if (s.source == SRC_NONE) return 23;
        b = (s.source == SRC_USB_HIGH_CURRENT) ? 13 : 18;
        case (s.phase)
            PH_COND: return b;
            PH_REDUCE: return b + 1;
            PH_CC: return b + 2;
            PH_CV: return b + 3;
            PH_DONE: return b + 4;
            default: return 23;
        endcase
    endfunction
    // States whose count is defined
    function automatic bit ok(csr_state_s s);
        if (s.source == SRC_ADAPTER)
            return s.phase != PH_REDUCE && !(s.watchdogOut &&
                (s.phase == PH_THERMAL || s.phase == PH_DONE));
        return s.source == SRC_NONE || s.phase != PH_THERMAL;
    endfunction
    task automatic compare_num(input logic [15:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("Checks %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // One query and its checks
    task automatic run_one(input csr_state_s s, input int w);
        int n;
        int f;
        int lw;
        int e;
        e = (w > SMAX) ? 23 : exp_code(s);
        @(posedge mclk);
        st <= s;
        u_host.query(w, WIN, n, f, lw);
        compare_num(16'(n), 16'(e));
        compare_num(16'(f), 16'(DLY + 3));
        compare_num(16'(lw), 16'(e * PER / 2));
        compare_num({15'h0000, busy}, 16'h0000);
    endtask
    // ********************************************************
    // Sequence
    // ********************************************************
    initial begin
        csr_state_s s;
        int i;
        int n;
        int f;
        int lw;
        void'($urandom(59381));
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        // Faults alone and all together
        for (i = 0; i < 4; i++) begin
            s = '0;
            s.source = SRC_ADAPTER;
            s[8:6] = (i == 3) ? 3'h7 : 3'(4 >> i);
            run_one(s, STROBE_MIN_CYC);
        end
        // Adapter and both USB sources, every phase and watchdog setting whose count is defined
        for (i = 0; i < 36; i++) begin
            s = '0;
            s.source = csr_src_e'(1 + i / 12);
            s.phase = csr_phase_e'((i % 12) / 2);
            s.watchdogOut = i[0];
            if (ok(s)) run_one(s, STROBE_MIN_CYC + 10);
        end
        s = '0;
        run_one(s, 60);
        s.source = SRC_ADAPTER;
        s.phase = PH_CC;
        run_one(s, 220);
        run_one(s, SMAX);
        run_one(s, SMAX + 1);
        // Reset in the middle of a burst, then query again
        u_host.query(STROBE_MIN_CYC, DLY + 20, n, f, lw);
        compare_num(16'(n), 16'h0003);
        reset_n <= 1'b0;
        @(posedge mclk);
        compare_num({15'h0000, lineOe_n}, 16'h0001);
        compare_num({15'h0000, busy}, 16'h0000);
        reset_n <= 1'b1;
        run_one(s, STROBE_MIN_CYC);
        for (i = 0; i < 12; i++) begin
            s = csr_state_s'(9'($urandom));
            if ($urandom % 4 != 0) s[8:6] = 3'h0;
            if (ok(s)) run_one(s, 50 + $urandom % 100);
        end
        give_verdict();
    end
    // Hang guard
    initial begin
        #400000;
        error_cnt++;
        give_verdict();
    end
endmodule
